/* File: src/msa_access.sv */
// Memory section access and protection controller.
// Assumes all inputs come from logic on core_clk; no pin crossing.
// Function
// - Flash store only from boot section or programmer
// - Boot flash store reaches all flash
// - Flash location is one 16-bit word
// - Separate lock levels per flash section
// - Table section: top of app, own lock
// - Production signature row never written, readable
// - Calibration copied at reset
// - Three-byte device ID and revision register
// - User row writable, survives chip erase
// - Fuses written only by programmer
// - Lock writes only tighten protection
// - Chip erase clears locks last
// - Unprogrammed bit reads one
// - EEPROM mapped at 0x1000 when selected
// - Direct I/O to 0x3f, bits 0x1f
// - Four bit-accessible general purpose registers
// - Four memory sets, parallel masters
// - I/O and SRAM access timing
// - EEPROM access timing
// - Software JTAG disable until a write of zero or reset
// - I/O lock blocks covered writes
// - I/O lock written only when unlocked
`timescale 1ns/100ps
module msa_access
  import msa_pkg::*;
#(
  parameter logic [16:0]         APP_W  = APP_WORDS,
  parameter logic [16:0]         BOOT_W = BOOT_WORDS,
  parameter int                  CAL_NUM = CAL_N,
  // Arbitrary identity values
  parameter logic [DEV_ID_W-1:0] DEV_ID = 24'h5a3c01,
  parameter logic [REV_W-1:0]    REV_ID = 4'h1
)
(
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire logic                      clk_en,
  input  wire logic                      nvm_req,
  input  wire logic                      nvm_prog,
  input  wire msa_cmd_e                  nvm_cmd,
  input  wire msa_tgt_e                  nvm_tgt,
  input  wire logic [FA_W-1:0]           nvm_pc,
  input  wire logic [FA_W-1:0]           nvm_addr,
  input  wire logic [FW_W-1:0]           nvm_wdata,
  input  wire logic                      nvm_done,
  input  wire logic [LOCK_W-1:0]         lock_nv,
  input  wire logic [FUSE_W-1:0]         fuse_nv,
  input  wire logic [7:0]                sig_rd_data,
  input  wire logic                      ee_map,
  input  wire logic [MST_N-1:0]          m_req,
  input  wire logic [MST_N-1:0]          m_we,
  input  wire logic [MST_N-1:0]          m_burst,
  input  wire logic [MST_N-1:0][DA_W-1:0] m_addr,
  input  wire logic                      iop_req,
  input  wire msa_iok_e                  iop_kind,
  input  wire logic [7:0]                iop_addr,
  input  wire logic [2:0]                iop_bit,
  input  wire logic [7:0]                iop_wdata,
  input  wire logic                      io_wr_req,
  input  wire msa_cls_e                  io_wr_cls,
  input  wire logic                      prot_wr,
  input  wire logic [2:0]                prot_val,
  input  wire logic                      ccp_open,
  input  wire logic                      jtag_ctl_wr,
  input  wire logic                      jtag_ctl_dis,
  input  wire logic                      jtag_ext_req,
  output logic                           nvm_go,
  output msa_cmd_e                       nvm_go_cmd,
  output msa_tgt_e                       nvm_go_tgt,
  output logic [FA_W-1:0]                nvm_go_addr,
  output logic [FW_W-1:0]                nvm_go_data,
  output logic                           nvm_deny,
  output logic                           nvm_busy,
  output logic [LOCK_W-1:0]              lock_rd,
  output logic [FUSE_W-1:0]              fuse_rd,
  output logic [SIG_AW-1:0]              sig_rd_addr,
  output logic                           cal_we,
  output logic [SIG_AW-1:0]              cal_idx,
  output logic [7:0]                     cal_data,
  output logic                           cpu_hold,
  output logic [DEV_ID_W-1:0]            dev_id,
  output logic [REV_W-1:0]               rev_id,
  output logic [MST_N-1:0]               m_gnt,
  output logic [MST_N-1:0]               m_ack,
  output logic                           iop_ok,
  output logic                           iop_fault,
  output logic [7:0]                     iop_rdata,
  output logic                           iop_tst,
  output logic [GPR_N-1:0][7:0]          gpr,
  output logic                           io_wr_ok,
  output logic [2:0]                     prot_lock,
  output logic                           jtag_off,
  output logic                           jtag_ext_ok
);
  if (CAL_NUM < 1 || CAL_NUM > 2 ** SIG_AW)
    $error("CAL_NUM out of range");
  if (BOOT_W == 17'h0 || BOOT_W > APP_W)
    $error("boot size must be nonzero and fit the application");

  typedef enum logic [2:0] {ST_LOAD, ST_CAL, ST_IDLE, ST_ERASE} msa_st_e;

  typedef struct packed {
    msa_st_e                 st;
    logic [1:0]              cal_ph;
    logic [SIG_AW-1:0]       cal_n;
    logic [SIG_AW-1:0]       sig_addr;
    logic                    cal_we;
    logic [SIG_AW-1:0]       cal_idx;
    logic [7:0]              cal_data;
    logic                    hold;
    logic                    busy;
    logic                    go;
    msa_cmd_e                go_cmd;
    msa_tgt_e                go_tgt;
    logic [FA_W-1:0]         go_addr;
    logic [FW_W-1:0]         go_data;
    logic                    deny;
    logic [FUSE_W-1:0]       fuse;
    logic [MST_N-1:0]        gnt;
    logic [MST_N-1:0][2:0]   pipe;
    logic [MST_N-1:0]        last;
    logic [GPR_N-1:0][7:0]   gpr;
    logic                    iop_ok;
    logic                    iop_fault;
    logic [7:0]              iop_rdata;
    logic                    iop_tst;
    logic                    io_ok;
    logic [2:0]              prot;
    logic                    jtag_off;
    logic                    jtag_ok;
    logic [DEV_ID_W-1:0]     dev_id;
    logic [REV_W-1:0]        rev_id;
  } msa_st_s;

  msa_st_s s;
  msa_st_s next_s;
  msa_lock_if lk ();

  msa_lock_unit u_lock (
    .core_clk (core_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .lk       (lk.unit)
  );

  function automatic logic in_boot(input logic [FA_W-1:0] a);
    return a >= APP_W;
  endfunction

  function automatic logic [1:0] lvl_of(input logic [LOCK_W-1:0] l,
                                        input logic [FA_W-1:0] a);
    if (in_boot(a))
      return l[LK_BOOT +: 2];
    else if (a >= APP_W - BOOT_W)
      return l[LK_TBL +: 2];
    else
      return l[LK_APP +: 2];
  endfunction

  function automatic msa_set_e dsel(input logic [DA_W-1:0] a, input logic map);
    if (a >= SRAM_BASE)
      return a[SRAM_BANK] ? MS_SR1 : MS_SR0;
    else if (map && a >= EE_BASE && a < EE_END)
      return MS_EE;
    else
      return MS_IO;
  endfunction

  // Latency in cycles from request to ack
  function automatic logic [1:0] lat(input msa_set_e t, input logic we);
    case (t)
      MS_IO: return LAT_IO;
      MS_EE: return we ? LAT_EE_WR : LAT_EE_RD;
      default: return we ? LAT_SR_WR : LAT_SR_RD;
    endcase
  endfunction

  logic                   nvm_ok;
  logic [MST_N-1:0][1:0]  lat_v;
  logic [MST_N-1:0]       acc;
  logic [3:0]             taken;

  // Request screening
  always_comb
  begin
    nvm_ok = 1'b0;
    case (nvm_cmd)
      NC_READ:
        nvm_ok = 1'b1;
      NC_WRITE, NC_ERASE:
        case (nvm_tgt)
          NT_FLASH:
            nvm_ok = (nvm_prog || in_boot(nvm_pc))
                     && lvl_of(lk.cur, nvm_addr) == LVL_OPEN;
          NT_USR_SIG:
            nvm_ok = 1'b1;
          NT_FUSE:
            nvm_ok = nvm_prog && nvm_cmd == NC_WRITE;
          NT_LOCK:
            nvm_ok = nvm_cmd == NC_WRITE && !lk.loose;
          default:
            nvm_ok = 1'b0;
        endcase
      NC_CHIP_ERASE:
        nvm_ok = nvm_prog;
      NC_USR_ERASE:
        nvm_ok = nvm_tgt == NT_USR_SIG;
      default:
        nvm_ok = 1'b0;
    endcase
  end

  // Lock store control
  assign lk.nv   = lock_nv;
  assign lk.load = s.st == ST_LOAD;
  assign lk.wval = nvm_wdata[LOCK_W-1:0];
  assign lk.wr   = s.st == ST_IDLE && nvm_req && nvm_ok && nvm_tgt == NT_LOCK
                   && nvm_cmd == NC_WRITE;
  assign lk.clr  = s.st == ST_ERASE && nvm_done;

  always_comb
  begin
    next_s = s;
    next_s.go      = 1'b0;
    next_s.deny    = 1'b0;
    next_s.cal_we  = 1'b0;
    next_s.iop_ok  = 1'b0;
    next_s.iop_fault = 1'b0;
    next_s.iop_tst = 1'b0;
    next_s.io_ok   = 1'b0;
    next_s.jtag_ok = 1'b0;
    taken = 4'h0;
    lat_v = '0;
    acc   = '0;

    case (s.st)
      ST_LOAD:
      begin
        // Nonvolatile settings taken after reset release
        next_s.fuse = fuse_nv;
        next_s.st   = ST_CAL;
      end
      ST_CAL:
      begin
        next_s.cal_ph = s.cal_ph + 2'h1;
        if (s.cal_ph == CAL_ISSUE)
          next_s.sig_addr = CAL_BASE + s.cal_n;
        if (s.cal_ph == CAL_TAKE)
        begin
          next_s.cal_ph   = CAL_ISSUE;
          next_s.cal_we   = 1'b1;
          next_s.cal_idx  = s.cal_n;
          next_s.cal_data = sig_rd_data;
          next_s.cal_n    = s.cal_n + 1'b1;
          if (s.cal_n == SIG_AW'(CAL_NUM - 1))
          begin
            next_s.st   = ST_IDLE;
            next_s.hold = 1'b0;
          end
        end
      end
      ST_IDLE:
        if (nvm_req)
        begin
          next_s.go      = nvm_ok;
          next_s.deny    = !nvm_ok;
          next_s.go_cmd  = nvm_cmd;
          next_s.go_tgt  = nvm_tgt;
          next_s.go_addr = nvm_addr;
          next_s.go_data = nvm_wdata;
          if (nvm_ok && nvm_cmd == NC_CHIP_ERASE)
          begin
            next_s.go_tgt = NT_FLASH;
            next_s.st     = ST_ERASE;
          end
        end
      ST_ERASE:
      begin
        // Busy while flash is erased; the lock store clears on done
        next_s.deny = nvm_req;
        if (nvm_done)
          next_s.st = ST_IDLE;
      end
      default:
        next_s.st = ST_LOAD;
    endcase
    if (s.st != ST_IDLE && s.st != ST_ERASE)
      next_s.deny = nvm_req;

    for (int i = 0; i < MST_N; i++)
    begin
      lat_v[i] = lat(dsel(m_addr[i], ee_map), m_we[i]);
      if (m_burst[i])
        acc[i] = !(dsel(m_addr[i], ee_map) == MS_EE && s.last[i]);
      else
        acc[i] = s.pipe[i][2:1] == 2'h0;
      acc[i] = acc[i] && m_req[i] && !taken[dsel(m_addr[i], ee_map)];
      if (acc[i])
        taken[dsel(m_addr[i], ee_map)] = 1'b1;
      next_s.gnt[i]  = acc[i];
      next_s.last[i] = acc[i];
      next_s.pipe[i] = (s.pipe[i] >> 1) | (acc[i] ? 3'h1 << (lat_v[i] - 2'h1) : 3'h0);
    end

    if (iop_req)
    begin
      if (iop_kind == IO_IN || iop_kind == IO_OUT)
        next_s.iop_ok = iop_addr <= IO_DIR_MAX;
      else
        next_s.iop_ok = iop_addr <= IO_BIT_MAX;
      next_s.iop_fault = !next_s.iop_ok;
      next_s.iop_rdata = 8'h00;
      if (next_s.iop_ok && iop_addr < 8'(GPR_N))
        case (iop_kind)
          IO_IN:  next_s.iop_rdata = s.gpr[iop_addr[1:0]];
          IO_OUT: next_s.gpr[iop_addr[1:0]] = iop_wdata;
          IO_SET: next_s.gpr[iop_addr[1:0]][iop_bit] = 1'b1;
          IO_CLR: next_s.gpr[iop_addr[1:0]][iop_bit] = 1'b0;
          IO_TST: next_s.iop_tst = s.gpr[iop_addr[1:0]][iop_bit];
          default: next_s.iop_rdata = 8'h00;
        endcase
    end

    case (io_wr_cls)
      CL_CLK:  next_s.io_ok = io_wr_req && !s.prot[0];
      CL_EVS:  next_s.io_ok = io_wr_req && !s.prot[1];
      CL_WEX:  next_s.io_ok = io_wr_req && !s.prot[2];
      default: next_s.io_ok = io_wr_req;
    endcase
    if (prot_wr && ccp_open)
      next_s.prot = prot_val;

    if (jtag_ctl_wr)
      next_s.jtag_off = jtag_ctl_dis;
    next_s.jtag_ok = jtag_ext_req && !s.jtag_off;
    // Busy kept in a flop so the output is not a decode
    next_s.busy = next_s.st != ST_IDLE;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s          <= '0;
      s.st       <= ST_LOAD;
      s.fuse     <= '1;
      s.hold     <= 1'b1;
      s.busy     <= 1'b1;
      s.go_cmd   <= NC_READ;
      s.go_tgt   <= NT_FLASH;
      s.dev_id   <= DEV_ID;
      s.rev_id   <= REV_ID;
    end
    else if (clk_en)
      s <= next_s;
  end

  assign nvm_go      = s.go;
  assign nvm_go_cmd  = s.go_cmd;
  assign nvm_go_tgt  = s.go_tgt;
  assign nvm_go_addr = s.go_addr;
  assign nvm_go_data = s.go_data;
  assign nvm_deny    = s.deny;
  assign nvm_busy    = s.busy;
  assign lock_rd     = lk.cur;
  assign fuse_rd     = s.fuse;
  assign sig_rd_addr = s.sig_addr;
  assign cal_we      = s.cal_we;
  assign cal_idx     = s.cal_idx;
  assign cal_data    = s.cal_data;
  assign cpu_hold    = s.hold;
  assign dev_id      = s.dev_id;
  assign rev_id      = s.rev_id;
  assign m_gnt       = s.gnt;
  assign iop_ok      = s.iop_ok;
  assign iop_fault   = s.iop_fault;
  assign iop_rdata   = s.iop_rdata;
  assign iop_tst     = s.iop_tst;
  assign gpr         = s.gpr;
  assign io_wr_ok    = s.io_ok;
  assign prot_lock   = s.prot;
  assign jtag_off    = s.jtag_off;
  assign jtag_ext_ok = s.jtag_ok;

  for (genvar g = 0; g < MST_N; g++)
  begin : g_ack
    assign m_ack[g] = s.pipe[g][0];
  end

  app_store_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && s.st == ST_IDLE && nvm_req && !nvm_prog && nvm_tgt == NT_FLASH
    && nvm_cmd == NC_WRITE && !in_boot(nvm_pc) |=> nvm_deny && !nvm_go)
    else $error("flash store from application taken");
  prod_row_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && nvm_req && nvm_tgt == NT_PROD_SIG
    && (nvm_cmd == NC_WRITE || nvm_cmd == NC_ERASE) |=> !nvm_go)
    else $error("production row write passed");
  fuse_sw_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && nvm_req && !nvm_prog && nvm_tgt == NT_FUSE
    && nvm_cmd == NC_WRITE |=> !nvm_go)
    else $error("software fuse write passed");
  io_bit_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && iop_req && iop_kind == IO_SET && iop_addr > IO_BIT_MAX
    |=> iop_fault && !iop_ok)
    else $error("bit op beyond range accepted");
  gpr_set_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && iop_req && iop_kind == IO_SET && iop_addr < 8'(GPR_N)
    |=> gpr[$past(iop_addr[1:0])][$past(iop_bit)])
    else $error("bit set lost");
  jtag_block_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && jtag_off && !jtag_ctl_wr |=> !jtag_ext_ok && jtag_off)
    else $error("JTAG access while disabled");
  io_lock_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && io_wr_req && io_wr_cls == CL_CLK && prot_lock[0] |=> !io_wr_ok)
    else $error("locked clock register written");
  ccp_guard_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && !(prot_wr && ccp_open) |=> $stable(prot_lock))
    else $error("I/O lock changed without unlock");
  sram_rd_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && acc[0] && !m_we[0] && dsel(m_addr[0], ee_map) == MS_SR0
    ##1 clk_en |=> m_ack[0])
    else $error("SRAM read ack not after two cycles");
endmodule // msa_access

/* File: include/msa_pkg.sv */
// Constants and types for the memory access and protection block.
// Assumes one core clock; every user imports the whole package.
package msa_pkg;
  localparam int          FW_W       = 16;
  localparam int          FA_W       = 17;
  localparam logic [16:0] APP_WORDS  = 17'h10000;
  localparam logic [16:0] BOOT_WORDS = 17'h01000;
  localparam int          DA_W       = 16;
  localparam logic [15:0] EE_BASE    = 16'h1000;
  localparam logic [15:0] EE_END     = 16'h1800;
  localparam logic [15:0] SRAM_BASE  = 16'h2000;
  localparam int          SRAM_BANK  = 12;
  localparam int          MST_N      = 3;
  localparam logic [7:0]  IO_DIR_MAX = 8'h3f;
  localparam logic [7:0]  IO_BIT_MAX = 8'h1f;
  localparam int          GPR_N      = 4;
  localparam int          LOCK_W     = 6;
  localparam logic [5:0]  LOCK_ERASED = 6'h3f;
  localparam int          LK_APP     = 0;
  localparam int          LK_TBL     = 2;
  localparam int          LK_BOOT    = 4;
  localparam logic [1:0]  LVL_OPEN   = 2'h3;
  localparam int          FUSE_W     = 8;
  localparam int          SIG_AW     = 8;
  localparam logic [7:0]  CAL_BASE   = 8'h00;
  localparam int          CAL_N      = 4;
  localparam logic [1:0]  LAT_IO     = 2'h1;
  localparam logic [1:0]  LAT_SR_WR  = 2'h1;
  localparam logic [1:0]  LAT_SR_RD  = 2'h2;
  localparam logic [1:0]  LAT_EE_WR  = 2'h1;
  localparam logic [1:0]  LAT_EE_RD  = 2'h3;
  localparam logic [1:0]  CAL_ISSUE  = 2'h0;
  localparam logic [1:0]  CAL_TAKE   = 2'h2;
  localparam int          DEV_ID_W   = 24;
  localparam int          REV_W      = 4;

  typedef enum logic [2:0] {NC_READ, NC_WRITE, NC_ERASE, NC_CHIP_ERASE,
                            NC_USR_ERASE} msa_cmd_e;
  typedef enum logic [2:0] {NT_FLASH, NT_USR_SIG, NT_PROD_SIG, NT_FUSE,
                            NT_LOCK} msa_tgt_e;
  typedef enum logic [1:0] {MS_IO, MS_EE, MS_SR0, MS_SR1} msa_set_e;
  typedef enum logic [2:0] {IO_IN, IO_OUT, IO_SET, IO_CLR, IO_TST} msa_iok_e;
  typedef enum logic [1:0] {CL_OTHER, CL_CLK, CL_EVS, CL_WEX} msa_cls_e;
endpackage

/* File: include/msa_lock_if.sv */
// Link between the access controller and its lock-bit store.
// Assumes both ends run on core_clk.
`timescale 1ns/100ps
interface msa_lock_if;
  import msa_pkg::*;
  logic              load;
  logic [LOCK_W-1:0] nv;
  logic              wr;
  logic [LOCK_W-1:0] wval;
  logic              clr;
  logic [LOCK_W-1:0] cur;
  logic              loose;
  modport ctrl (output load, nv, wr, wval, clr, input cur, loose);
  modport unit (input load, nv, wr, wval, clr, output cur, loose);
endinterface

/* File: src/msa_lock_unit.sv */
// Lock-bit store: one-way tightening, cleared only by erase or reset.
// Assumes the controller sequences load, write and clear.
`timescale 1ns/100ps
module msa_lock_unit
  import msa_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  msa_lock_if.unit lk
);
  typedef struct packed {
    logic [LOCK_W-1:0] cur;
  } msa_lk_s;

  msa_lk_s s;
  msa_lk_s next_s;

  assign lk.loose = |(lk.wval & ~s.cur);
  assign lk.cur   = s.cur;

  always_comb
  begin
    next_s = s;
    if (lk.clr)
      next_s.cur = LOCK_ERASED;
    else if (lk.load)
      next_s.cur = lk.nv;
    else if (lk.wr)
      next_s.cur = s.cur & lk.wval;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      s.cur <= LOCK_ERASED;
    else if (clk_en)
      s <= next_s;
  end

  lock_and_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && lk.wr && !lk.clr && !lk.load |=> s.cur == ($past(s.cur) & $past(lk.wval)))
    else $error("lock write not an AND");
  lock_clr_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en && lk.clr |=> s.cur == LOCK_ERASED)
    else $error("lock erase did not clear");
endmodule // msa_lock_unit

/* File: verification/msa_nvm_model.sv */
// Far-side model: flash array and production signature row.
// Assumes it sits beside msa_access on core_clk.
`timescale 1ns/100ps
module msa_nvm_model
  import msa_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              nvm_go,
  input  wire msa_cmd_e          nvm_go_cmd,
  input  wire logic [SIG_AW-1:0] sig_rd_addr,
  output logic                   nvm_done,
  output logic [7:0]             sig_rd_data,
  output logic [LOCK_W-1:0]      lock_nv,
  output logic [FUSE_W-1:0]      fuse_nv
);
  logic [3:0]        cnt = 4'h0;
  assign lock_nv = LOCK_ERASED;
  assign fuse_nv = 8'h5c;
  // row data one flop behind address
  always @(posedge core_clk)
  begin
    sig_rd_data <= sig_rd_addr ^ 8'h6b;
  end
  always @(posedge core_clk)
  begin
    nvm_done <= (cnt == 4'h1);
    if (nvm_go && nvm_go_cmd == NC_CHIP_ERASE)
      cnt <= 4'h6;
    else if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
  end
endmodule // msa_nvm_model

/* File: verification/msa_access_tb.sv */
// Self-checking bench for msa_access, one task per scenario.
// Assumes msa_nvm_model as flash array and signature row.
`timescale 1ns/100ps
module msa_access_tb;
  import msa_pkg::*;
  // Arbitrary identity values
  localparam logic [23:0] DID = 24'h3c5a02;
  localparam logic [3:0]  RID = 4'h2;
  logic core_clk = 0, rst = 1, clk_en = 1, nvm_req = 0, nvm_prog = 0, nvm_done;
  msa_cmd_e nvm_cmd = NC_READ, nvm_go_cmd;
  msa_tgt_e nvm_tgt = NT_FLASH, nvm_go_tgt;
  logic [FA_W-1:0] nvm_pc = 0, nvm_addr = 0, nvm_go_addr;
  logic [FW_W-1:0] nvm_wdata = 0, nvm_go_data;
  logic [LOCK_W-1:0] lock_nv, lock_rd;
  logic [7:0] fuse_nv, fuse_rd, sig_rd_data, cal_data, iop_addr = 0, iop_wdata = 0, iop_rdata;
  logic [SIG_AW-1:0] sig_rd_addr, cal_idx;
  logic ee_map = 0, iop_req = 0, io_wr_req = 0, prot_wr = 0, ccp_open = 0;
  logic jtag_ctl_wr = 0, jtag_ctl_dis = 0, jtag_ext_req = 0;
  logic [MST_N-1:0] m_req = 0, m_we = 0, m_burst = 0, m_gnt, m_ack;
  logic [MST_N-1:0][DA_W-1:0] m_addr = '0;
  msa_iok_e iop_kind = IO_IN;
  msa_cls_e io_wr_cls = CL_OTHER;
  logic [2:0] iop_bit = 0, prot_val = 0, prot_lock;
  logic nvm_go, nvm_deny, nvm_busy, cal_we, cpu_hold, iop_ok, iop_fault, iop_tst;
  logic io_wr_ok, jtag_off, jtag_ext_ok;
  logic [DEV_ID_W-1:0] dev_id;
  logic [REV_W-1:0] rev_id;
  logic [GPR_N-1:0][7:0] gpr;
  int n_mismatch = 0, cmp_count = 0, ncal = 0;
  msa_access #(.DEV_ID(DID), .REV_ID(RID)) i_dut (.*);
  msa_nvm_model i_far (.*);
  always #5 core_clk = ~core_clk;
  task automatic chk(input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  always @(posedge core_clk)
    if (cal_we === 1'b1)
    begin
      ncal++;
      chk(cal_data, cal_idx ^ 8'h6b);
    end
  task t_reset;
    #1;
    chk(fuse_rd, 8'hff);
    chk(nvm_busy, 1'b1);
    for (int i = 0; i < 99 && cpu_hold !== 1'b0; i++)
      @(posedge core_clk);
    #1;
    chk(ncal, CAL_N);
    chk(fuse_rd, 8'h5c);
    chk(lock_rd, LOCK_ERASED);
    chk(dev_id, DID);
    chk(rev_id, RID);
    $display("reset test done");
  endtask
  task automatic nv(input logic p, msa_cmd_e c, msa_tgt_e t, logic [16:0] pc, a,
                    logic [15:0] d, logic g);
    @(posedge core_clk);
    nvm_req <= 1;
    nvm_prog <= p;
    nvm_cmd <= c;
    nvm_tgt <= t;
    nvm_pc <= pc;
    nvm_addr <= a;
    nvm_wdata <= d;
    @(posedge core_clk);
    nvm_req <= 0;
    #1;
    chk(nvm_go, g);
    chk(nvm_deny, !g);
    if (g)
    begin
      chk(nvm_go_addr, a);
      chk(nvm_go_cmd, c);
    end
  endtask
  task t_nvm;
    nv(0, NC_WRITE, NT_FLASH, 17'h00100, 17'h00200, 16'h1234, 0);
    nv(0, NC_WRITE, NT_FLASH, 17'h10010, 17'h10020, 16'hbeef, 1);
    chk(nvm_go_data, 16'hbeef);
    nv(0, NC_WRITE, NT_PROD_SIG, 17'h10010, 4, 0, 0);
    nv(1, NC_ERASE, NT_PROD_SIG, 0, 4, 0, 0);
    nv(1, NC_READ, NT_PROD_SIG, 0, 4, 0, 1);
    nv(0, NC_WRITE, NT_USR_SIG, 17'h10010, 2, 16'h55aa, 1);
    nv(0, NC_USR_ERASE, NT_USR_SIG, 17'h10010, 0, 0, 1);
    nv(0, NC_WRITE, NT_FUSE, 17'h10010, 0, 16'h00f0, 0);
    nv(1, NC_WRITE, NT_FUSE, 0, 0, 16'h00f0, 1);
    nv(0, NC_WRITE, NT_LOCK, 17'h10010, 0, 16'h003c, 1);
    chk(lock_rd, 6'h3c);
    nv(1, NC_WRITE, NT_LOCK, 0, 0, 16'h003f, 0);
    chk(lock_rd, 6'h3c);
    nv(0, NC_WRITE, NT_FLASH, 17'h10010, 17'h00200, 0, 0);
    nv(0, NC_WRITE, NT_FLASH, 17'h10010, 17'h0f000, 0, 1);
    nv(0, NC_CHIP_ERASE, NT_FLASH, 17'h10010, 0, 0, 0);
    nv(1, NC_CHIP_ERASE, NT_USR_SIG, 0, 0, 0, 1);
    chk(nvm_go_tgt, NT_FLASH);
    chk(nvm_busy, 1'b1);
    chk(lock_rd, 6'h3c);
    for (int i = 0; i < 30 && nvm_busy !== 1'b0; i++)
      @(posedge core_clk);
    #1;
    chk(lock_rd, LOCK_ERASED);
    $display("nvm test done");
  endtask
  task automatic mem(input int i, logic we, logic [15:0] a, int lat);
    int n;
    @(posedge core_clk);
    m_req[i] <= 1;
    m_we[i] <= we;
    m_addr[i] <= a;
    @(posedge core_clk);
    m_req[i] <= 0;
    #1;
    chk(m_gnt[i], 1'b1);
    for (n = 1; n < 8 && m_ack[i] !== 1'b1; n++)
      @(posedge core_clk) #1;
    chk(n, lat);
  endtask
  task t_mem;
    mem(0, 0, 16'h0040, LAT_IO);
    mem(0, 1, 16'h2000, LAT_SR_WR);
    mem(1, 0, 16'h3000, LAT_SR_RD);
    mem(1, 0, 16'h1004, LAT_IO);
    @(posedge core_clk) ee_map <= 1;
    mem(0, 1, 16'h1004, LAT_EE_WR);
    mem(1, 0, 16'h1004, LAT_EE_RD);
    @(posedge core_clk) m_req <= 3'b011;
    m_addr <= {16'h0, 16'h0040, 16'h2000};
    m_we <= 0;
    @(posedge core_clk) m_req <= 0;
    #1 chk(m_gnt, 3'b011);
    repeat (4) @(posedge core_clk);
    m_req <= 3'b011;
    m_addr <= {16'h0, 16'h2004, 16'h2000};
    @(posedge core_clk) m_req <= 0;
    #1 chk(m_gnt, 3'b001);
    @(posedge core_clk) m_req <= 3'b110;
    m_burst <= 3'b110;
    m_addr <= {16'h1004, 16'h3000, 16'h0000};
    @(posedge core_clk) #1 chk(m_gnt, 3'b110);
    @(posedge core_clk) #1 chk(m_gnt, 3'b010);
    @(posedge core_clk) #1 chk(m_gnt, 3'b110);
    @(posedge core_clk) m_req <= 0;
    m_burst <= 0;
    $display("memory test done");
  endtask
  task automatic io(input msa_iok_e k, logic [7:0] a, logic [2:0] b, logic ok);
    @(posedge core_clk);
    iop_req <= 1;
    iop_kind <= k;
    iop_addr <= a;
    iop_bit <= b;
    @(posedge core_clk);
    iop_req <= 0;
    #1;
    chk(iop_ok, ok);
    chk(iop_fault, !ok);
  endtask
  task t_io;
    io(IO_SET, 8'h01, 3, 1);
    chk(gpr[1][3], 1'b1);
    io(IO_TST, 8'h01, 3, 1);
    chk(iop_tst, 1'b1);
    io(IO_CLR, 8'h01, 3, 1);
    chk(gpr[1][3], 1'b0);
    @(posedge core_clk) iop_wdata <= 8'ha5;
    io(IO_OUT, 8'h02, 0, 1);
    chk(gpr[2], 8'ha5);
    io(IO_IN, 8'h02, 0, 1);
    chk(iop_rdata, 8'ha5);
    io(IO_SET, 8'h1f, 0, 1);
    io(IO_SET, 8'h20, 0, 0);
    io(IO_OUT, 8'h3f, 0, 1);
    io(IO_IN, 8'h40, 0, 0);
    $display("io test done");
  endtask
  task automatic pw(input logic [2:0] v, logic o, logic [2:0] e);
    @(posedge core_clk) prot_wr <= 1;
    prot_val <= v;
    ccp_open <= o;
    @(posedge core_clk) prot_wr <= 0;
    #1 chk(prot_lock, e);
  endtask
  task automatic wr(input msa_cls_e c, logic ok);
    @(posedge core_clk) io_wr_req <= 1;
    io_wr_cls <= c;
    @(posedge core_clk) io_wr_req <= 0;
    #1 chk(io_wr_ok, ok);
  endtask
  task t_prot;
    pw(3'b101, 1, 3'b101);
    pw(3'b010, 0, 3'b101);
    wr(CL_CLK, 0);
    wr(CL_WEX, 0);
    wr(CL_EVS, 1);
    wr(CL_OTHER, 1);
    $display("protect test done");
  endtask
  task automatic jx(input logic ok);
    @(posedge core_clk) jtag_ext_req <= 1;
    @(posedge core_clk) jtag_ext_req <= 0;
    #1 chk(jtag_ext_ok, ok);
  endtask
  task automatic jc(input logic d);
    @(posedge core_clk) jtag_ctl_wr <= 1;
    jtag_ctl_dis <= d;
    @(posedge core_clk) jtag_ctl_wr <= 0;
    #1 chk(jtag_off, d);
  endtask
  task t_jtag;
    jx(1);
    jc(1);
    jx(0);
    jc(0);
    jx(1);
    jc(1);
    @(posedge core_clk) rst <= 1;
    repeat (6) @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk) #1 chk(jtag_off, 1'b0);
    $display("jtag test done");
  endtask
  task end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst <= 0;
    t_reset;
    t_nvm;
    t_mem;
    t_io;
    t_prot;
    t_jtag;
    end_of_test;
  end
  // Whole run is well under a thousand cycles
  initial
  begin
    #50000;
    n_mismatch++;
    end_of_test;
  end
endmodule // msa_access_tb
